// ### rtl/ldh_device.sv
// deactivation handshake of the documented transceiver, either role
// assumes the peer end sits across ldh_if on the same clock
`timescale 1ns/1ps
module ldh_device #(
  parameter logic [39:0] ACTIVE_CYCLES = 40'(ldh_pkg::MIN_ACTIVE_CYCLES),
  parameter int LOSS_CYCLES = ldh_pkg::LOSS_OF_SYNC_WORD_ERROR_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // link side
  ldh_if.dev link,
  // user side
  input wire logic capable,
  input wire logic warm_en,
  input wire logic deact_start,
  input wire logic deact_cancel,
  input wire logic inhibit,
  input wire logic wake,
  output logic tx_on,
  output logic low_power,
  output logic role_a,
  output logic refused,
  output logic peer_capable
);
  import ldh_pkg::*;
  // ==========================================================================
  // elaboration checks
  if (LOSS_CYCLES < 1 || LOSS_CYCLES > 255)
  begin : g_bad_loss
    $error("ldh_device: LOSS_CYCLES out of range");
  end
  if (ACTIVE_CYCLES == 40'h0)
  begin : g_bad_active
    $error("ldh_device: ACTIVE_CYCLES must be nonzero");
  end
  // ==========================================================================
  // state
  ldh_state_e state;
  ldh_state_e next_state;
  logic [ACT_W-1:0] active_cnt;
  logic [7:0] loss_cnt;
  logic send;
  logic [7:0] send_id;
  logic send_flag;
  logic [3:0] send_addr;
  logic next_refused;
  logic next_role_a;
  // ==========================================================================
  // receive decode
  logic rx_req;
  logic rx_cancel;
  logic rx_accept;
  logic rx_refuse;
  logic rx_utc;
  ldh_msg_codec u_codec (
    .valid(link.p2d_valid),
    .addr(link.p2d_addr),
    .msg(link.p2d_msg),
    .is_req(rx_req),
    .is_cancel(rx_cancel),
    .is_accept(rx_accept),
    .is_refuse(rx_refuse),
    .is_utc(rx_utc)
  );
  // ==========================================================================
  // gating terms
  // the active timer restarts on every return from low power
  wire active_ok = !warm_en || active_cnt >= ACTIVE_CYCLES;
  wire far_lost = loss_cnt >= 8'(LOSS_CYCLES);
  wire can_start = capable && active_ok && !inhibit;
  wire can_accept = capable && active_ok && !inhibit;
  // ==========================================================================
  // next state and message selection
  always_comb
  begin
    next_state = state;
    send = 1'b0;
    send_id = MSG_ID_RSP;
    send_flag = FLAG_GO;
    send_addr = ADDR_UNICAST;
    next_refused = 1'b0;
    next_role_a = role_a;
    case (state)
      ST_IDLE:
      begin
        if (rx_req)
        begin
          send = 1'b1;
          next_role_a = 1'b0;
          if (!capable)
          begin
            send_id = MSG_ID_UTC;
          end
          else if (!can_accept)
          begin
            send_flag = FLAG_STOP;
          end
          else
          begin
            next_state = ST_B_WAIT;
          end
        end
        else if (deact_start && can_start)
        begin
          send = 1'b1;
          send_id = MSG_ID_REQ;
          send_addr = ADDR_BCAST;
          next_role_a = 1'b1;
          next_state = ST_A_WAIT;
        end
      end
      ST_A_WAIT:
      begin
        if (inhibit || deact_cancel)
        begin
          send = 1'b1;
          send_id = MSG_ID_REQ;
          send_addr = ADDR_BCAST;
          send_flag = FLAG_STOP;
          next_state = ST_IDLE;
        end
        else if (rx_accept)
        begin
          next_state = ST_LOW;
        end
        else if (rx_refuse || rx_utc)
        begin
          next_refused = 1'b1;
          next_state = ST_IDLE;
        end
        else if (rx_req)
        begin
          // both ends started at once: refuse theirs and keep waiting on ours
          send = 1'b1;
          send_flag = FLAG_STOP;
        end
      end
      ST_B_WAIT:
      begin
        if (rx_cancel)
        begin
          next_state = ST_IDLE;
        end
        else if (inhibit)
        begin
          send = 1'b1;
          send_flag = FLAG_STOP;
          next_state = ST_IDLE;
        end
        else if (far_lost)
        begin
          next_state = ST_LOW;
        end
      end
      ST_LOW:
      begin
        if (wake)
        begin
          next_state = ST_IDLE;
        end
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
  end
  // ==========================================================================
  // registers
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state <= ST_IDLE;
      tx_on <= 1'b1;
      role_a <= 1'b0;
      refused <= 1'b0;
    end
    else
    begin
      state <= next_state;
      tx_on <= next_state != ST_LOW;
      role_a <= next_role_a;
      refused <= next_refused;
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      link.d2p_valid <= 1'b0;
      link.d2p_addr <= ADDR_UNICAST;
      link.d2p_msg <= MSG_RESET;
    end
    else
    begin
      link.d2p_valid <= send;
      if (send)
      begin
        link.d2p_addr <= send_addr;
        link.d2p_msg <= ldh_build(send_id, send_flag);
      end
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      active_cnt <= '0;
      loss_cnt <= 8'h00;
    end
    else
    begin
      if (state == ST_LOW)
      begin
        active_cnt <= '0;
      end
      else if (!active_ok)
      begin
        active_cnt <= active_cnt + 40'h1;
      end
      // silence only counts while waiting as B
      if (state != ST_B_WAIT || link.p2d_tx_on)
      begin
        loss_cnt <= 8'h00;
      end
      else if (!far_lost)
      begin
        loss_cnt <= loss_cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      peer_capable <= 1'b0;
    end
    else if (rx_req || rx_cancel || rx_accept || rx_refuse)
    begin
      peer_capable <= 1'b1;
    end
  end

  assign link.d2p_tx_on = tx_on;
  assign low_power = state == ST_LOW;
endmodule : ldh_device

// ### rtl/ldh_pkg.sv
// shared constants, message layout and state codes for the deactivation handshake
// assumes both ends run on one clock at 250 MHz and share this package
package ldh_pkg;
  // ==========================================================================
  // message identifiers and addressing
  localparam logic [7:0] MSG_ID_REQ = 8'h16;
  localparam logic [7:0] MSG_ID_RSP = 8'h96;
  localparam logic [7:0] MSG_ID_UTC = 8'h81;
  localparam logic [3:0] ADDR_BCAST = 4'hf;
  localparam logic [3:0] ADDR_UNICAST = 4'h1;
  // ==========================================================================
  // field positions of the three-octet message
  localparam int ID_LSB = 16;
  localparam int OCT2_LSB = 8;
  localparam int FLAG_POS = OCT2_LSB;
  localparam logic FLAG_GO = 1'b0;
  localparam logic FLAG_STOP = 1'b1;
  localparam logic [23:0] MSG_RESET = 24'h000000;
  // ==========================================================================
  // timing
  localparam longint unsigned CLK_HZ = 64'd250_000_000;
  localparam longint unsigned MIN_ACTIVE_MIN = 64'd5;
  localparam longint unsigned MIN_ACTIVE_CYCLES = MIN_ACTIVE_MIN * 64'd60 * CLK_HZ;
  localparam int LOSS_OF_SYNC_WORD_ERROR_CYCLES = 8;
  localparam int ACT_W = 40;
  // ==========================================================================
  // types
  typedef logic [23:0] ldh_msg_t;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_A_WAIT = 4'h2,
    ST_B_WAIT = 4'h4,
    ST_LOW = 4'h8
  } ldh_state_e;

  // builds id in octet 1, flag in bit 0 of octet 2, all reserved bits zero
  function automatic ldh_msg_t ldh_build(input logic [7:0] id, input logic flag);
    ldh_msg_t m;
    m = MSG_RESET;
    m[ID_LSB +: 8] = id;
    m[FLAG_POS] = flag;
    return m;
  endfunction : ldh_build
endpackage : ldh_pkg

// ### rtl/ldh_if.sv
// message channel and line activity between the two transceivers
// assumes both ends are clocked by the same clock
`timescale 1ns/1ps
interface ldh_if;
  import ldh_pkg::*;
  // device to peer
  logic d2p_valid;
  logic [3:0] d2p_addr;
  ldh_msg_t d2p_msg;
  logic d2p_tx_on;
  // peer to device
  logic p2d_valid;
  logic [3:0] p2d_addr;
  ldh_msg_t p2d_msg;
  logic p2d_tx_on;

  modport dev (
    output d2p_valid, d2p_addr, d2p_msg, d2p_tx_on,
    input p2d_valid, p2d_addr, p2d_msg, p2d_tx_on
  );
  modport peer (
    input d2p_valid, d2p_addr, d2p_msg, d2p_tx_on,
    output p2d_valid, p2d_addr, p2d_msg, p2d_tx_on
  );
endinterface : ldh_if

// ### rtl/ldh_msg_codec.sv
// classifies a received embedded channel message
// assumes a one-cycle valid beside a stable address and message
`timescale 1ns/1ps
module ldh_msg_codec (
  // received message
  input wire logic valid,
  input wire logic [3:0] addr,
  input wire ldh_pkg::ldh_msg_t msg,
  // classification
  output logic is_req,
  output logic is_cancel,
  output logic is_accept,
  output logic is_refuse,
  output logic is_utc
);
  import ldh_pkg::*;
  // ==========================================================================
  // decode
  wire [7:0] id = msg[ID_LSB +: 8];
  wire flag = msg[FLAG_POS];
  // reserved bits are not checked so a sender with stray bits is still heard
  wire req_hit = valid && id == MSG_ID_REQ && addr == ADDR_BCAST;
  wire rsp_hit = valid && id == MSG_ID_RSP;
  assign is_req = req_hit && flag == FLAG_GO;
  assign is_cancel = req_hit && flag == FLAG_STOP;
  assign is_accept = rsp_hit && flag == FLAG_GO;
  assign is_refuse = rsp_hit && flag == FLAG_STOP;
  assign is_utc = valid && id == MSG_ID_UTC;
endmodule : ldh_msg_codec

// ### rtl/ldh_peer.sv
// deactivation handshake of the far transceiver, either role
// assumes the device end sits across ldh_if on the same clock
`timescale 1ns/1ps
module ldh_peer #(
  parameter logic [39:0] ACTIVE_CYCLES = 40'(ldh_pkg::MIN_ACTIVE_CYCLES),
  parameter int LOSS_CYCLES = ldh_pkg::LOSS_OF_SYNC_WORD_ERROR_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // link side
  ldh_if.peer link,
  // user side
  input wire logic warm_en,
  input wire logic deact_start,
  input wire logic inhibit,
  input wire logic wake,
  output logic tx_on,
  output logic low_power
);
  import ldh_pkg::*;
  // ==========================================================================
  // elaboration checks
  if (LOSS_CYCLES < 1 || LOSS_CYCLES > 255)
  begin : g_bad_loss
    $error("ldh_peer: LOSS_CYCLES out of range");
  end
  // ==========================================================================
  // state and decode
  ldh_state_e state;
  ldh_state_e next_state;
  logic [ACT_W-1:0] active_cnt;
  logic [7:0] loss_cnt;
  logic send;
  logic [7:0] send_id;
  logic send_flag;
  logic rx_req;
  logic rx_cancel;
  logic rx_accept;
  logic rx_refuse;
  logic rx_utc;
  ldh_msg_codec u_codec (
    .valid(link.d2p_valid),
    .addr(link.d2p_addr),
    .msg(link.d2p_msg),
    .is_req(rx_req),
    .is_cancel(rx_cancel),
    .is_accept(rx_accept),
    .is_refuse(rx_refuse),
    .is_utc(rx_utc)
  );
  wire active_ok = !warm_en || active_cnt >= ACTIVE_CYCLES;
  wire far_lost = loss_cnt >= 8'(LOSS_CYCLES);
  wire ok = active_ok && !inhibit;
  // ==========================================================================
  // next state
  always_comb
  begin
    next_state = state;
    send = 1'b0;
    send_id = MSG_ID_RSP;
    send_flag = FLAG_GO;
    case (state)
      ST_IDLE:
      begin
        if (rx_req)
        begin
          send = 1'b1;
          send_flag = !ok;
          next_state = ok ? ST_B_WAIT : ST_IDLE;
        end
        else if (deact_start && ok)
        begin
          send = 1'b1;
          send_id = MSG_ID_REQ;
          next_state = ST_A_WAIT;
        end
      end
      ST_A_WAIT:
      begin
        if (inhibit)
        begin
          send = 1'b1;
          send_id = MSG_ID_REQ;
          send_flag = FLAG_STOP;
          next_state = ST_IDLE;
        end
        else if (rx_accept)
        begin
          next_state = ST_LOW;
        end
        else if (rx_refuse || rx_utc)
        begin
          next_state = ST_IDLE;
        end
        else if (rx_req)
        begin
          send = 1'b1;
          send_flag = FLAG_STOP;
        end
      end
      ST_B_WAIT:
      begin
        if (rx_cancel)
        begin
          next_state = ST_IDLE;
        end
        else if (inhibit)
        begin
          send = 1'b1;
          send_flag = FLAG_STOP;
          next_state = ST_IDLE;
        end
        else if (far_lost)
        begin
          next_state = ST_LOW;
        end
      end
      ST_LOW:
      begin
        if (wake)
        begin
          next_state = ST_IDLE;
        end
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
  end
  // ==========================================================================
  // registers
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state <= ST_IDLE;
      tx_on <= 1'b1;
      link.p2d_valid <= 1'b0;
      link.p2d_addr <= ADDR_UNICAST;
      link.p2d_msg <= MSG_RESET;
    end
    else
    begin
      state <= next_state;
      tx_on <= next_state != ST_LOW;
      link.p2d_valid <= send;
      if (send)
      begin
        link.p2d_addr <= send_id == MSG_ID_REQ ? ADDR_BCAST : ADDR_UNICAST;
        link.p2d_msg <= ldh_build(send_id, send_flag);
      end
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      active_cnt <= '0;
      loss_cnt <= 8'h00;
    end
    else
    begin
      if (state == ST_LOW)
      begin
        active_cnt <= '0;
      end
      else if (!active_ok)
      begin
        active_cnt <= active_cnt + 40'h1;
      end
      if (state != ST_B_WAIT || link.d2p_tx_on)
      begin
        loss_cnt <= 8'h00;
      end
      else if (!far_lost)
      begin
        loss_cnt <= loss_cnt + 8'h01;
      end
    end
  end

  assign link.p2d_tx_on = tx_on;
  assign low_power = state == ST_LOW;
endmodule : ldh_peer

// ### tb/ldh_link_asserts.sv
// concurrent checks on the link between device and peer
// assumes one clock, async active-high reset, instantiated beside ldh_if
`timescale 1ns/1ps
module ldh_link_asserts #(
  parameter int LOSS_CYCLES = 8
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // device to peer
  input wire logic d2p_valid,
  input wire logic [3:0] d2p_addr,
  input wire ldh_pkg::ldh_msg_t d2p_msg,
  input wire logic d2p_tx_on,
  // peer to device
  input wire logic p2d_valid,
  input wire logic [3:0] p2d_addr,
  input wire ldh_pkg::ldh_msg_t p2d_msg,
  input wire logic p2d_tx_on
);
  import ldh_pkg::*;
  // ==========
  // helpers
  localparam ldh_msg_t REQ_GO = {MSG_ID_REQ, 16'h0000};
  localparam ldh_msg_t RSP_OK = {MSG_ID_RSP, 16'h0000};
  logic dev_a;
  logic d_acc;
  logic p_acc;
  logic [3:0] d_quiet;
  logic [3:0] p_quiet;
  // a peer message ends our pending request only in a cycle we do not send, so a collision leaves it set until our refusal goes out
  wire next_dev_a = d2p_valid ? (d2p_msg == REQ_GO) : (p2d_valid ? 1'b0 : dev_a);
  // quiet counters saturate: only the threshold matters
  wire [3:0] next_d_quiet = d2p_tx_on ? 4'h0 : ((d_quiet == 4'hf) ? 4'hf : d_quiet + 4'h1);
  wire [3:0] next_p_quiet = p2d_tx_on ? 4'h0 : ((p_quiet == 4'hf) ? 4'hf : p_quiet + 4'h1);
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      dev_a <= 1'b0;
      d_acc <= 1'b0;
      p_acc <= 1'b0;
    end
    else
    begin
      dev_a <= next_dev_a;
      d_acc <= d2p_valid && (d2p_msg == RSP_OK);
      p_acc <= p2d_valid && (p2d_msg == RSP_OK);
    end
  end
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      d_quiet <= 4'h0;
      p_quiet <= 4'h0;
    end
    else
    begin
      d_quiet <= next_d_quiet;
      p_quiet <= next_p_quiet;
    end
  end
  // ==========
  // properties
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  AST_D_REQ_ADDR: assert property (d2p_valid && d2p_msg[23:16] == MSG_ID_REQ
    |-> d2p_addr == ADDR_BCAST) else $error("device request not broadcast");
  AST_P_REQ_ADDR: assert property (p2d_valid && p2d_msg[23:16] == MSG_ID_REQ
    |-> p2d_addr == ADDR_BCAST) else $error("peer request not broadcast");
  AST_D_RESV: assert property (d2p_valid
    |-> d2p_msg[15:9] == 7'h00 && d2p_msg[7:0] == 8'h00) else $error("device reserved bits");
  AST_P_RESV: assert property (p2d_valid
    |-> p2d_msg[15:9] == 7'h00 && p2d_msg[7:0] == 8'h00) else $error("peer reserved bits");
  AST_D_ANSWER: assert property (p2d_valid && p2d_msg == REQ_GO && p2d_addr == ADDR_BCAST
    && d2p_tx_on |=> d2p_valid && (d2p_msg[23:16] == MSG_ID_RSP
    || d2p_msg[23:16] == MSG_ID_UTC)) else $error("device did not answer request");
  AST_P_ANSWER: assert property (d2p_valid && d2p_msg == REQ_GO && d2p_addr == ADDR_BCAST
    && p2d_tx_on |=> p2d_valid && (p2d_msg[23:16] == MSG_ID_RSP
    || p2d_msg[23:16] == MSG_ID_UTC)) else $error("peer did not answer request");
  AST_D_A_STOP: assert property (dev_a && p2d_valid && p2d_msg == RSP_OK && !d2p_valid
    |=> !d2p_tx_on || d2p_valid) else $error("device kept sending after acceptance");
  AST_D_FALL: assert property ($fell(d2p_tx_on)
    |-> p_acc || p_quiet >= LOSS_CYCLES) else $error("device stopped without cause");
  AST_P_FALL: assert property ($fell(p2d_tx_on)
    |-> d_acc || d_quiet >= LOSS_CYCLES) else $error("peer stopped without cause");
endmodule : ldh_link_asserts

// ### tb/tb_top.sv
// self-checking bench: device and peer joined by ldh_if, both user sides driven
// assumes ldh_pkg, ldh_if and both ends are compiled first
`timescale 1ns/1ps
module tb_top;
  import ldh_pkg::*;
  // short timer keeps the run small
  localparam logic [39:0] ACT = 40'd20;
  localparam int LOSS = 4;
  logic clock, rst, capable, d_warm, d_start, d_cancel, d_inh, d_wake;
  logic p_warm, p_start, p_inh, p_wake, saw_ref;
  logic d_tx, d_low, d_role, d_ref, d_pcap, p_tx, p_low;
  logic [31:0] r;
  ldh_msg_t m;
  logic [3:0] a;
  int errors, samples_checked, cycles, seed;
  ldh_if link ();
  ldh_device #(.ACTIVE_CYCLES(ACT), .LOSS_CYCLES(LOSS)) u_ldh_device (.clock(clock),
    .rst(rst), .link(link.dev), .capable(capable), .warm_en(d_warm), .deact_start(d_start),
    .deact_cancel(d_cancel), .inhibit(d_inh), .wake(d_wake), .tx_on(d_tx),
    .low_power(d_low), .role_a(d_role), .refused(d_ref), .peer_capable(d_pcap));
  ldh_peer #(.ACTIVE_CYCLES(ACT), .LOSS_CYCLES(LOSS)) u_ldh_peer (.clock(clock), .rst(rst),
    .link(link.peer), .warm_en(p_warm), .deact_start(p_start), .inhibit(p_inh),
    .wake(p_wake), .tx_on(p_tx), .low_power(p_low));
  ldh_link_asserts #(.LOSS_CYCLES(LOSS)) u_ldh_link_asserts (.clock(clock), .rst(rst),
    .d2p_valid(link.d2p_valid), .d2p_addr(link.d2p_addr), .d2p_msg(link.d2p_msg),
    .d2p_tx_on(link.d2p_tx_on), .p2d_valid(link.p2d_valid), .p2d_addr(link.p2d_addr),
    .p2d_msg(link.p2d_msg), .p2d_tx_on(link.p2d_tx_on));
  // ==========
  // helpers
  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  always @(posedge clock)
  begin
    if (d_ref === 1'b1)
      saw_ref <= 1'b1;
  end
  function automatic ldh_msg_t exp_msg(input logic [7:0] id, input logic flag);
    return {id, 7'h00, flag, 8'h00};
  endfunction : exp_msg
  task automatic check(input string what, input logic [27:0] seen, input logic [27:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic finish_test();
    if (errors == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : finish_test
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask : cyc
  // a message is visible for one cycle only, so look before waiting
  task automatic wait_msg(input logic from_dev);
    int k;
    k = 0;
    while ((from_dev ? link.d2p_valid : link.p2d_valid) !== 1'b1 && k < 50)
    begin
      k++;
      @(negedge clock);
    end
    // a message that never comes counts against the run
    if (k == 50)
      errors++;
    m = from_dev ? link.d2p_msg : link.p2d_msg;
    a = from_dev ? link.d2p_addr : link.p2d_addr;
  endtask : wait_msg
  task automatic start(input logic from_dev);
    d_start = from_dev;
    p_start = !from_dev;
    cyc(1);
    d_start = 1'b0;
    p_start = 1'b0;
  endtask : start
  task automatic exchange(input logic from_dev, input logic inh, input logic refuse);
    saw_ref = 1'b0;
    p_inh = from_dev & inh;
    d_inh = !from_dev & inh;
    start(from_dev);
    wait_msg(from_dev);
    check("request", {a, m}, {ADDR_BCAST, exp_msg(MSG_ID_REQ, FLAG_GO)});
    cyc(1);
    wait_msg(!from_dev);
    check("response", {a, m}, {ADDR_UNICAST, exp_msg(MSG_ID_RSP, refuse)});
    cyc(2);
    check("starter", {from_dev ? d_tx : p_tx, saw_ref}, {refuse, from_dev & refuse});
    check("responder_tx", from_dev ? p_tx : d_tx, 1'b1);
    cyc(LOSS + 3);
    check("low", {d_low, p_low}, {2{!refuse}});
    check("role", {d_role, d_pcap}, {from_dev, 1'b1});
    d_inh = 1'b0;
    p_inh = 1'b0;
    d_wake = 1'b1;
    p_wake = 1'b1;
    cyc(1);
    d_wake = 1'b0;
    p_wake = 1'b0;
    cyc(3);
    check("awake", {d_tx, p_tx}, 2'b11);
  endtask : exchange
  // ==========
  // hang guard
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      errors++;
      finish_test();
    end
  end
  // ==========
  // main sequence
  initial
  begin
    seed = 14;
    errors = 0;
    samples_checked = 0;
    cycles = 0;
    saw_ref = 1'b0;
    {rst, capable, d_warm, p_warm} = 4'hf;
    {d_start, d_cancel, d_inh, d_wake, p_start, p_inh, p_wake} = 7'h00;
    repeat (12) @(posedge clock);
    @(negedge clock);
    rst = 1'b0;
    cyc(1);
    // own warm timer still running: no request may leave the device
    start(1'b1);
    check("warm_hold", {d_role, link.d2p_valid}, 2'b00);
    d_warm = 1'b0;
    // peer warm timer still running: refused without any inhibit
    exchange(1'b1, 1'b0, 1'b1);
    cyc(ACT);
    exchange(1'b1, 1'b0, 1'b0);
    d_warm = 1'b0;
    p_warm = 1'b0;
    exchange(1'b0, 1'b0, 1'b0);
    exchange(1'b0, 1'b1, 1'b1);
    repeat (8)
    begin
      r = $random(seed);
      exchange(r[0], r[1], r[1]);
    end
    // cancel right behind the request races the far end's acceptance, from either end
    for (int i = 0; i < 2; i++)
    begin
      start(i == 0);
      d_cancel = (i == 0);
      p_inh = (i != 0);
      cyc(1);
      d_cancel = 1'b0;
      p_inh = 1'b0;
      wait_msg(i == 0);
      check("cancel", {a, m}, {ADDR_BCAST, exp_msg(MSG_ID_REQ, FLAG_STOP)});
      cyc(LOSS + 4);
      check("cancel_idle", {d_tx, p_tx, d_low, p_low}, 4'hc);
    end
    // feature absent: unable reply, starter keeps running
    capable = 1'b0;
    start(1'b0);
    wait_msg(1'b0);
    cyc(1);
    wait_msg(1'b1);
    check("unable", m, exp_msg(MSG_ID_UTC, FLAG_GO));
    cyc(LOSS + 3);
    check("unable_stay", {p_tx, p_low, d_tx}, 3'h5);
    finish_test();
  end
endmodule : tb_top
